// [limit_switch_output.sv]
// Top of the limit switching output: supervision, hysteresis and drive.
`timescale 1ns/1ns
`default_nettype none
module limit_switch_output
   import limit_switch_pkg::*;
(
   input  wire logic                       i_clk,           // 25 MHz system clock.
   input  wire logic                       i_rst,           // Synchronous reset, active high.
   input  wire logic                       i_meas_valid,    // One-cycle strobe per new measurement.
   input  wire logic [SRC_COUNT*VAL_W-1:0] i_values,        // Distances one to six, then calculated value.
   input  wire logic                       i_err_intensity, // Intensity error of this measurement.
   input  wire logic                       i_err_range,     // Measuring-range error of this measurement.
   input  wire logic [SRC_W-1:0]           i_source,        // Monitored value select.
   input  wire logic [1:0]                 i_level,         // Output level convention.
   input  wire logic [1:0]                 i_behaviour,     // Switching behaviour.
   input  wire logic [1:0]                 i_err_sel,       // Error condition select.
   input  wire value_t                     i_upper_limit,   // Upper limit, signed value units.
   input  wire value_t                     i_lower_limit,   // Lower limit, signed value units.
   input  wire value_t                     i_hysteresis,    // Hysteresis, signed value units.
   input  wire logic                       i_short_pin,     // Short-circuit sense pin.
   input  wire logic                       i_sw_reset,      // Software reset command pulse.
   output logic                            o_high_on,       // High-side transistor conducts.
   output logic                            o_low_on,        // Low-side transistor conducts.
   output logic                            o_active,        // Logical switching state.
   output logic                            o_short_latched  // Short protection latched.
);
   sample_if smp ();

   logic         short_meta_reg;
   logic         short_sync_reg;
   limit_state_t state_reg;
   limit_state_t state_next;
   logic         active_reg;
   logic         active_next;
   logic         err_hit;
   logic         above_upper;
   logic         below_upper_rel;
   logic         below_lower;
   logic         above_lower_rel;
   logic         upper_en;
   logic         lower_en;
   value_t       upper_rel;
   value_t       lower_rel;

   sample_select u_select (
      .i_clk           (i_clk),
      .i_rst           (i_rst),
      .i_meas_valid    (i_meas_valid),
      .i_source        (i_source),
      .i_values        (i_values),
      .i_err_intensity (i_err_intensity),
      .i_err_range     (i_err_range),
      .smp             (smp)
   );

   // Release thresholds carry the hysteresis band.
   assign upper_rel = value_t'(i_upper_limit - i_hysteresis);
   assign lower_rel = value_t'(i_lower_limit + i_hysteresis);

   assign upper_en        = (i_behaviour == BEH_UPPER) || (i_behaviour == BEH_BOTH);
   assign lower_en        = (i_behaviour == BEH_LOWER) || (i_behaviour == BEH_BOTH);
   assign above_upper     = smp.value > i_upper_limit;
   assign below_upper_rel = smp.value < upper_rel;
   assign below_lower     = smp.value < i_lower_limit;
   assign above_lower_rel = smp.value > lower_rel;

   assign err_hit = (i_err_sel == ERR_INTENSITY) ? smp.err_intensity :
                    (i_err_sel == ERR_RANGE) ? smp.err_range :
                    (smp.err_intensity | smp.err_range);

   always_comb begin
      state_next  = state_reg;
      active_next = active_reg;
      if (smp.valid) begin
         if (i_behaviour == BEH_ERROR) begin
            state_next  = ST_IDLE;
            active_next = err_hit;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (upper_en && above_upper) begin
                     state_next = ST_UPPER;
                  end else if (lower_en && below_lower) begin
                     state_next = ST_LOWER;
                  end
               end
               ST_UPPER: begin
                  if (!upper_en || below_upper_rel) begin
                     state_next = (lower_en && below_lower) ? ST_LOWER : ST_IDLE;
                  end
               end
               ST_LOWER: begin
                  if (!lower_en || above_lower_rel) begin
                     state_next = (upper_en && above_upper) ? ST_UPPER : ST_IDLE;
                  end
               end
               default: begin
                  state_next = ST_IDLE;
               end
            endcase
            active_next = (state_next != ST_IDLE);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         short_meta_reg <= 1'b0;
         short_sync_reg <= 1'b0;
         state_reg      <= ST_IDLE;
         active_reg     <= 1'b0;
      end else begin
         short_meta_reg <= i_short_pin;
         short_sync_reg <= short_meta_reg;
         state_reg      <= state_next;
         active_reg     <= active_next;
      end
   end
   assign o_active = active_reg;

   output_stage u_stage (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_active   (active_reg),
      .i_level    (i_level),
      .i_short_s  (short_sync_reg),
      .i_sw_reset (i_sw_reset),
      .o_high_on  (o_high_on),
      .o_low_on   (o_low_on),
      .o_latched  (o_short_latched)
   );

   upper_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
      smp.valid && i_behaviour == BEH_UPPER && above_upper |=> active_reg)
      else $error("upper limit not activating");
   upper_rel_a: assert property (@(posedge i_clk) disable iff (i_rst)
      smp.valid && i_behaviour == BEH_UPPER && state_reg == ST_UPPER && below_upper_rel
      |=> !active_reg)
      else $error("upper hysteresis release missed");
   upper_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
      smp.valid && i_behaviour == BEH_UPPER && state_reg == ST_UPPER && !below_upper_rel
      |=> active_reg)
      else $error("upper released inside hysteresis");
   lower_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
      smp.valid && i_behaviour == BEH_LOWER && below_lower |=> active_reg)
      else $error("lower limit not activating");
   lower_rel_a: assert property (@(posedge i_clk) disable iff (i_rst)
      smp.valid && i_behaviour == BEH_LOWER && state_reg == ST_LOWER && above_lower_rel
      |=> !active_reg)
      else $error("lower hysteresis release missed");
   err_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
      smp.valid && i_behaviour == BEH_ERROR |=> active_reg == $past(err_hit))
      else $error("error mode output wrong");
   hold_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !smp.valid |=> $stable(active_reg))
      else $error("output changed without measurement");
   short_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_short_latched |-> !o_high_on && !o_low_on)
      else $error("drive while short latched");
   pp_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_level == LEVEL_PP && !o_short_latched && $stable(i_level) && $stable(active_reg)
      ##1 $stable(active_reg) && !o_short_latched |-> o_high_on == active_reg)
      else $error("push-pull drive mismatch");

   upper_cov_c: cover property (@(posedge i_clk) state_reg == ST_UPPER ##[1:20] state_reg == ST_IDLE);
   lower_cov_c: cover property (@(posedge i_clk) state_reg == ST_LOWER ##[1:20] state_reg == ST_IDLE);
   err_cov_c:   cover property (@(posedge i_clk) i_behaviour == BEH_ERROR && active_reg);
   short_cov_c: cover property (@(posedge i_clk) o_short_latched ##1 !o_short_latched);
endmodule : limit_switch_output
`default_nettype wire

// [limit_switch_pkg.sv]
// Shared constants and types for the limit switching output.
package limit_switch_pkg;
   localparam int unsigned VAL_W        = 32;
   localparam int unsigned SRC_COUNT    = 7;
   localparam int unsigned SRC_W        = 3;
   localparam logic [2:0]  SRC_CALC     = 3'h6;
   localparam logic [1:0]  LEVEL_NPN    = 2'h0;
   localparam logic [1:0]  LEVEL_PNP    = 2'h1;
   localparam logic [1:0]  LEVEL_PP     = 2'h2;
   localparam logic [1:0]  LEVEL_PP_INV = 2'h3;
   localparam logic [1:0]  ERR_INTENSITY = 2'h0;
   localparam logic [1:0]  ERR_RANGE     = 2'h1;
   localparam logic [1:0]  ERR_EITHER    = 2'h2;
   localparam logic [1:0]  BEH_ERROR  = 2'h0;
   localparam logic [1:0]  BEH_UPPER  = 2'h1;
   localparam logic [1:0]  BEH_LOWER  = 2'h2;
   localparam logic [1:0]  BEH_BOTH   = 2'h3;
   typedef logic signed [VAL_W-1:0] value_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_UPPER = 3'b010,
      ST_LOWER = 3'b100
   } limit_state_t;
endpackage : limit_switch_pkg

// [sample_if.sv]
// Interface carrying one selected sample and its error flags.
`timescale 1ns/1ns
`default_nettype none
interface sample_if;
   import limit_switch_pkg::*;
   logic   valid;
   value_t value;
   logic   err_intensity;
   logic   err_range;
   modport src (output valid, output value, output err_intensity, output err_range);
   modport dst (input valid, input value, input err_intensity, input err_range);
endinterface : sample_if
`default_nettype wire

// [sample_select.sv]
// Registers the selected monitored value of each new measurement.
`timescale 1ns/1ns
`default_nettype none
module sample_select
   import limit_switch_pkg::*;
(
   input  wire logic                   i_clk,           // System clock.
   input  wire logic                   i_rst,           // Synchronous reset.
   input  wire logic                   i_meas_valid,    // New measurement strobe.
   input  wire logic [SRC_W-1:0]       i_source,        // Monitored source select.
   input  wire logic [SRC_COUNT*VAL_W-1:0] i_values,    // Six distances and a calculated value.
   input  wire logic                   i_err_intensity, // Intensity error of measurement.
   input  wire logic                   i_err_range,     // Measuring-range error of measurement.
   sample_if.src                       smp              // Selected sample out.
);
   logic              valid_reg;
   value_t            value_reg;
   logic              ei_reg;
   logic              er_reg;
   logic [SRC_W-1:0]  src_clamped;
   value_t            sel_value;

   // Out-of-range codes fall back to the calculated value.
   assign src_clamped = (i_source > SRC_CALC) ? SRC_CALC : i_source;
   assign sel_value   = value_t'(i_values[src_clamped*VAL_W +: VAL_W]);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         valid_reg <= 1'b0;
         value_reg <= '0;
         ei_reg    <= 1'b0;
         er_reg    <= 1'b0;
      end else begin
         valid_reg <= i_meas_valid;
         if (i_meas_valid) begin
            value_reg <= sel_value;
            ei_reg    <= i_err_intensity;
            er_reg    <= i_err_range;
         end
      end
   end

   assign smp.valid         = valid_reg;
   assign smp.value         = value_reg;
   assign smp.err_intensity = ei_reg;
   assign smp.err_range     = er_reg;

   src_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_meas_valid |=> valid_reg && value_reg == $past(sel_value))
      else $error("selected sample not captured");
endmodule : sample_select
`default_nettype wire

// [output_stage.sv]
// Maps the logical switch state onto transistor drive and short protection.
`timescale 1ns/1ns
`default_nettype none
module output_stage
   import limit_switch_pkg::*;
(
   input  wire logic       i_clk,       // System clock.
   input  wire logic       i_rst,       // Synchronous reset.
   input  wire logic       i_active,    // Logical switch state.
   input  wire logic [1:0] i_level,     // Output level convention.
   input  wire logic       i_short_s,   // Synchronised short-circuit sense.
   input  wire logic       i_sw_reset,  // Software reset command pulse.
   output logic            o_high_on,   // High-side transistor conducts.
   output logic            o_low_on,    // Low-side transistor conducts.
   output logic            o_latched    // Short protection latched.
);
   logic latch_reg;
   logic latch_next;
   logic hi_req;
   logic lo_req;

   // Clearing requires both the command and the short gone; a new short wins.
   assign latch_next = i_short_s ? 1'b1 : (i_sw_reset ? 1'b0 : latch_reg);

   // Active state puts the relevant transistor into conduction.
   assign hi_req = (i_level == LEVEL_PNP) ? i_active :
                   (i_level == LEVEL_PP) ? i_active :
                   (i_level == LEVEL_PP_INV) ? ~i_active : 1'b0;
   assign lo_req = (i_level == LEVEL_NPN) ? i_active :
                   (i_level == LEVEL_PP) ? ~i_active :
                   (i_level == LEVEL_PP_INV) ? i_active : 1'b0;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         latch_reg <= 1'b0;
         o_high_on <= 1'b0;
         o_low_on  <= 1'b0;
      end else begin
         latch_reg <= latch_next;
         o_high_on <= hi_req & ~latch_next;
         o_low_on  <= lo_req & ~latch_next;
      end
   end
   assign o_latched = latch_reg;

   latch_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      latch_reg && !i_sw_reset |=> latch_reg)
      else $error("short latch released without command");
   npn_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_level == LEVEL_NPN && i_active && !latch_next |=> o_low_on && !o_high_on)
      else $error("npn active not conducting");
endmodule : output_stage
`default_nettype wire

// [ext_load.sv]
// Behavioural load on the switching output, with a short that the bench can apply and remove.
`timescale 1ns/1ns
`default_nettype none
module ext_load (
   input  wire logic i_high_on,   // High-side transistor conducts.
   input  wire logic i_low_on,    // Low-side transistor conducts.
   input  wire logic i_short_req, // Bench asks for a shorted load.
   output logic      o_short_pin  // Overcurrent sense.
);
   // Current flows into the short only while a transistor conducts; removing the short drops the sense.
   assign o_short_pin = i_short_req & (i_high_on | i_low_on);
endmodule : ext_load
`default_nettype wire

// [tb_limit_switch_output.sv]
// Self-checking bench for the limit switching output.
`timescale 1ns/1ns
`default_nettype none
module tb_limit_switch_output;
   import limit_switch_pkg::*;
   logic                       i_clk, i_rst, i_meas_valid, i_err_intensity, i_err_range;
   logic                       i_sw_reset, short_req, i_short_pin;
   logic                       o_high_on, o_low_on, o_active, o_short_latched;
   logic [SRC_COUNT*VAL_W-1:0] i_values;
   logic [SRC_W-1:0]           i_source;
   logic [1:0]                 i_level, i_behaviour, i_err_sel, st;
   value_t                     i_upper_limit, i_lower_limit, i_hysteresis;
   logic [15:0]                rnd;
   logic                       ea;
   int                         n_errors, checks;

   limit_switch_output i_limit_switch_output (.i_clk(i_clk), .i_rst(i_rst), .i_meas_valid(i_meas_valid),
      .i_values(i_values), .i_err_intensity(i_err_intensity), .i_err_range(i_err_range), .i_source(i_source),
      .i_level(i_level), .i_behaviour(i_behaviour), .i_err_sel(i_err_sel), .i_upper_limit(i_upper_limit),
      .i_lower_limit(i_lower_limit), .i_hysteresis(i_hysteresis), .i_short_pin(i_short_pin),
      .i_sw_reset(i_sw_reset), .o_high_on(o_high_on), .o_low_on(o_low_on), .o_active(o_active),
      .o_short_latched(o_short_latched));
   ext_load i_ext_load (.i_high_on(o_high_on), .i_low_on(o_low_on), .i_short_req(short_req),
      .o_short_pin(i_short_pin));

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic logic [1:0] drv(input logic [1:0] l, input logic a);
      case (l)
         LEVEL_NPN: return {1'b0, a};
         LEVEL_PNP: return {a, 1'b0};
         LEVEL_PP:  return {a, ~a};
         default:   return {~a, a};
      endcase
   endfunction : drv

   // Hysteresis state: 0 idle, 1 above upper, 2 below lower.
   function automatic logic [1:0] nxt(input logic [1:0] s, input value_t v);
      if (s == 2'h1 && !(v < i_upper_limit - i_hysteresis)) return 2'h1;
      if (s == 2'h2 && !(v > i_lower_limit + i_hysteresis)) return 2'h2;
      if (i_behaviour[0] && v > i_upper_limit) return 2'h1;
      if (i_behaviour[1] && v < i_lower_limit) return 2'h2;
      return 2'h0;
   endfunction : nxt

   task automatic chk(input logic [1:0] g, input logic [1:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic do_reset(input int n);
      @(posedge i_clk);
      #2;
      i_rst = 1'b1;
      repeat (n) @(posedge i_clk);
      #2;
      i_rst = 1'b0;
      st = 2'h0;
      ea = 1'b0;
      chk({o_high_on, o_low_on}, 2'h0);
      chk({o_active, o_short_latched}, 2'h0);
   endtask : do_reset

   task automatic meas(input value_t v, input logic ei, input logic er);
      int k;
      @(posedge i_clk);
      #2;
      i_source = rnd[2:0];
      k = (rnd[2:0] == 3'h7) ? 6 : int'(rnd[2:0]);
      i_values = {SRC_COUNT{~v}};
      i_values[k*VAL_W +: VAL_W] = v;
      i_err_intensity = ei;
      i_err_range = er;
      i_meas_valid = 1'b1;
      @(posedge i_clk);
      #2;
      i_meas_valid = 1'b0;
      st = nxt(st, v);
      ea = (i_behaviour != BEH_ERROR) ? (st != 2'h0) :
           (i_err_sel == ERR_INTENSITY) ? ei : (i_err_sel == ERR_RANGE) ? er : (ei | er);
      repeat (2) @(posedge i_clk);
      #1;
      chk({1'b0, o_active}, {1'b0, ea});
      @(posedge i_clk);
      #1;
      chk({o_high_on, o_low_on}, drv(i_level, ea));
   endtask : meas

   task automatic phase(input logic [1:0] b, input logic [1:0] l);
      value_t u, d, h;
      value_t cv [0:9];
      @(posedge i_clk);
      #2;
      i_behaviour = b;
      i_level = l;
      i_err_sel = l;
      do_reset(2);
      u = i_upper_limit;
      d = i_lower_limit;
      h = i_hysteresis;
      cv = '{u + 1, u, u - h, u - h - 1, d - 1, d, d + h, d + h + 1, u + 1, d - 1};
      for (int n = 0; n < 16; n++) begin
         rnd = lfsr(rnd);
         meas((n < 10) ? cv[n] : value_t'(int'(rnd % 16'h0BB8)) - 32'sh5DC, rnd[4], rnd[5]);
      end
      @(posedge i_clk);
      #2;
      i_values = ~i_values;
      i_err_intensity = ~i_err_intensity;
      i_err_range = ~i_err_range;
      repeat (4) @(posedge i_clk);
      #1;
      chk({1'b0, o_active}, {1'b0, ea});
      $display("test behaviour=%0d level=%0d done", b, l);
   endtask : phase

   initial begin
      #(40 * 6000);
      n_errors++;
      end_of_test();
   end

   initial begin
      {i_rst, i_meas_valid, i_err_intensity, i_err_range, i_sw_reset, short_req} = 6'h00;
      i_values = '0;
      i_source = 3'h0;
      {i_level, i_behaviour, i_err_sel} = 6'h00;
      i_upper_limit = 32'sh000003E8;
      i_lower_limit = -32'sh000003E8;
      i_hysteresis = 32'sh00000064;
      rnd = 16'h0018;
      do_reset(8);
      for (int b = 0; b < 4; b++) begin
         for (int l = 0; l < 4; l++) begin
            phase(b[1:0], l[1:0]);
         end
      end
      @(posedge i_clk);
      #2;
      short_req = 1'b1;
      for (int i = 0; i < 8 && o_short_latched !== 1'b1; i++) @(posedge i_clk);
      #1;
      chk({1'b0, o_short_latched}, 2'h1);
      chk({o_high_on, o_low_on}, 2'h0);
      @(posedge i_clk);
      #2;
      short_req = 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      chk({1'b0, o_short_latched}, 2'h1);
      @(posedge i_clk);
      #2;
      i_sw_reset = 1'b1;
      @(posedge i_clk);
      #2;
      i_sw_reset = 1'b0;
      chk({1'b0, o_short_latched}, 2'h0);
      @(posedge i_clk);
      #1;
      chk({o_high_on, o_low_on}, drv(i_level, ea));
      $display("test short protection done");
      end_of_test();
   end
endmodule : tb_limit_switch_output
`default_nettype wire
